// ==== esd_seq_top.sv ====
// Enable sequencing for two linear regulators and two general outputs,
// plus output type, pin gating and configuration bits.
// Assumes a serial front end drives the register port on i_clk; enable pin is asynchronous.
`timescale 1ns/1ps

module esd_seq_top
  import esd_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_MS_CYCLES  // Cycles per half ms step
)
(
  input  wire logic       i_clk,                    // 10 MHz system clock
  input  wire logic       i_reset_n,                // Async reset, active low
  input  wire logic       i_enable_pin,             // Raw enable pin
  input  wire logic       i_reg_wr_en,              // Register write strobe
  input  wire logic [7:0] i_reg_addr,               // Register address
  input  wire logic [7:0] i_reg_wdata,              // Register write data
  output logic      [7:0] o_reg_rdata,              // Register read data, one cycle late
  output logic            o_linear_reg_a_en,        // Regulator A enable
  output logic            o_linear_reg_b_en,        // Regulator B enable
  output logic            o_general_output_a,       // Output A drive value
  output logic            o_general_output_a_oe_n,  // Output A enable, low drives
  output logic            o_general_output_b,       // Shared pin drive value
  output logic            o_general_output_b_oe_n,  // Shared pin enable, low drives
  output logic            o_ext_clock_select,       // Shared pin used as clock input
  output logic            o_shared_pin_pulldown,    // Shared pin pull-down on
  output logic            o_enable_pin_pulldown,    // Enable pin pull-down on
  output logic            o_thermal_warn_threshold, // Thermal warning threshold select
  output logic            o_spread_spectrum_on      // Spread spectrum enable
);

  initial
  begin
    if (HALF_CYC < 1 || 2 * HALF_CYC > (1 << STEP_CNT_W))
      $error("esd_seq_top: HALF_CYC out of range");
  end

  // Drive value and enable for one pin from level and type
  function automatic logic [1:0] pin_drive(input logic value, input logic open_drain);
    // Returns {drive value, enable_n}
    if (open_drain)
      pin_drive = {1'b0, value};
    else
      pin_drive = {value, 1'b0};
  endfunction

  // Register file
  esd_delay_t    linreg_a_seq_delay;
  esd_delay_t    linreg_b_seq_delay;
  esd_delay_t    out_a_seq_delay;
  esd_delay_t    out_b_seq_delay;
  esd_out_ctrl_t general_output_control;
  esd_config_t   device_config;

  // Enable pin edges
  logic enable_level;
  logic enable_rise;
  logic enable_fall;

  // Sequenced levels
  logic linreg_a_seq;
  logic linreg_b_seq;
  logic out_a_seq;
  logic out_b_seq;

  // Combined pin values
  logic       next_out_a_value;
  logic       next_out_b_value;
  logic [1:0] next_out_a_pin;
  logic [1:0] next_out_b_pin;
  logic [7:0] next_rdata;

  esd_pin_sync u_enable_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_enable_pin),
    .o_level   (enable_level),
    .o_rise    (enable_rise),
    .o_fall    (enable_fall)
  );

  // Register writes
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      linreg_a_seq_delay <= DELAY_RESET;
      linreg_b_seq_delay <= DELAY_RESET;
      out_a_seq_delay    <= DELAY_RESET;
      out_b_seq_delay    <= DELAY_RESET;
    end
    else if (i_reg_wr_en)
    begin
      case (i_reg_addr)
        ADDR_LINREG_A_SEQ_DELAY: linreg_a_seq_delay <= i_reg_wdata;
        ADDR_LINREG_B_SEQ_DELAY: linreg_b_seq_delay <= i_reg_wdata;
        ADDR_OUT_A_SEQ_DELAY:    out_a_seq_delay    <= i_reg_wdata;
        ADDR_OUT_B_SEQ_DELAY:    out_b_seq_delay    <= i_reg_wdata;
        default:
        begin
          linreg_a_seq_delay <= linreg_a_seq_delay;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      general_output_control <= OUT_CTRL_RESET;
    else if (i_reg_wr_en && i_reg_addr == ADDR_GENERAL_OUTPUT_CTRL)
      general_output_control <= i_reg_wdata & OUT_CTRL_WMASK;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      device_config <= CONFIG_RESET;
    else if (i_reg_wr_en && i_reg_addr == ADDR_DEVICE_CONFIG)
      device_config <= i_reg_wdata;
  end

  // Register reads
  always_comb
  begin
    case (i_reg_addr)
      ADDR_LINREG_A_SEQ_DELAY:  next_rdata = linreg_a_seq_delay;
      ADDR_LINREG_B_SEQ_DELAY:  next_rdata = linreg_b_seq_delay;
      ADDR_OUT_A_SEQ_DELAY:     next_rdata = out_a_seq_delay;
      ADDR_OUT_B_SEQ_DELAY:     next_rdata = out_b_seq_delay;
      ADDR_GENERAL_OUTPUT_CTRL: next_rdata = general_output_control;
      ADDR_DEVICE_CONFIG:       next_rdata = device_config;
      default:                  next_rdata = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reg_rdata <= READ_UNMAPPED;
    else
      o_reg_rdata <= next_rdata;
  end

  // Sequencing channels
  esd_seq_channel #(
    .HALF_CYC (HALF_CYC)
  ) u_linreg_a (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_rise      (enable_rise),
    .i_fall      (enable_fall),
    .i_rise_code (linreg_a_seq_delay.rise),
    .i_fall_code (linreg_a_seq_delay.fall),
    .i_on_range  (device_config.on_range),
    .i_off_range (device_config.off_range),
    .o_level     (linreg_a_seq)
  );

  esd_seq_channel #(
    .HALF_CYC (HALF_CYC)
  ) u_linreg_b (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_rise      (enable_rise),
    .i_fall      (enable_fall),
    .i_rise_code (linreg_b_seq_delay.rise),
    .i_fall_code (linreg_b_seq_delay.fall),
    .i_on_range  (device_config.on_range),
    .i_off_range (device_config.off_range),
    .o_level     (linreg_b_seq)
  );

  esd_seq_channel #(
    .HALF_CYC (HALF_CYC)
  ) u_out_a (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_rise      (enable_rise),
    .i_fall      (enable_fall),
    .i_rise_code (out_a_seq_delay.rise),
    .i_fall_code (out_a_seq_delay.fall),
    .i_on_range  (device_config.on_range),
    .i_off_range (device_config.off_range),
    .o_level     (out_a_seq)
  );

  esd_seq_channel #(
    .HALF_CYC (HALF_CYC)
  ) u_out_b (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_rise      (enable_rise),
    .i_fall      (enable_fall),
    .i_rise_code (out_b_seq_delay.rise),
    .i_fall_code (out_b_seq_delay.fall),
    .i_on_range  (device_config.on_range),
    .i_off_range (device_config.off_range),
    .o_level     (out_b_seq)
  );

  // General output levels and pin drive
  always_comb
  begin
    next_out_a_value = general_output_control.out_a_level &
                       (~general_output_control.out_a_pin_gating | out_a_seq);
    next_out_b_value = general_output_control.out_b_level &
                       (~general_output_control.out_b_pin_gating | out_b_seq);
    next_out_a_pin   = pin_drive(next_out_a_value,
                                 general_output_control.out_a_open_drain);
    next_out_b_pin   = pin_drive(next_out_b_value,
                                 general_output_control.out_b_open_drain);
    // Shared pin released when it serves as clock input
    if (device_config.shared_pin_function)
      next_out_b_pin = 2'b01;
  end

  // Regulator enables lag their channels by one cycle
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_linear_reg_a_en <= 1'b0;
      o_linear_reg_b_en <= 1'b0;
    end
    else
    begin
      o_linear_reg_a_en <= linreg_a_seq;
      o_linear_reg_b_en <= linreg_b_seq;
    end
  end

  // Output A pin drive
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_general_output_a      <= 1'b0;
      o_general_output_a_oe_n <= 1'b0;
    end
    else
    begin
      o_general_output_a      <= next_out_a_pin[1];
      o_general_output_a_oe_n <= next_out_a_pin[0];
    end
  end

  // Shared pin drive, released while it serves as clock input
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_general_output_b      <= 1'b0;
      o_general_output_b_oe_n <= 1'b0;
    end
    else
    begin
      o_general_output_b      <= next_out_b_pin[1];
      o_general_output_b_oe_n <= next_out_b_pin[0];
    end
  end

  // Configuration outputs
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_ext_clock_select       <= 1'b0;
      o_shared_pin_pulldown    <= 1'b0;
      o_enable_pin_pulldown    <= 1'b0;
      o_thermal_warn_threshold <= 1'b0;
      o_spread_spectrum_on     <= 1'b0;
    end
    else
    begin
      o_ext_clock_select       <= device_config.shared_pin_function;
      o_shared_pin_pulldown    <= device_config.shared_pin_pulldown;
      o_enable_pin_pulldown    <= device_config.enable_pin_pulldown;
      o_thermal_warn_threshold <= device_config.thermal_warn_threshold;
      o_spread_spectrum_on     <= device_config.spread_spectrum_on;
    end
  end

endmodule

// ==== esd_pkg.sv ====
// Constants, register map and field layouts for the enable sequencing block.
// Assumes a 10 MHz system clock and an external serial front end that owns the register port.
package esd_pkg;

  // System clock and step timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned HALF_MS_STEP_NS = 500_000;
  localparam int unsigned HALF_MS_CYCLES = (HALF_MS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W     = 14;

  // Register addresses
  localparam logic [7:0] ADDR_LINREG_A_SEQ_DELAY  = 8'h0E;
  localparam logic [7:0] ADDR_LINREG_B_SEQ_DELAY  = 8'h0F;
  localparam logic [7:0] ADDR_OUT_A_SEQ_DELAY     = 8'h10;
  localparam logic [7:0] ADDR_OUT_B_SEQ_DELAY     = 8'h11;
  localparam logic [7:0] ADDR_GENERAL_OUTPUT_CTRL = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_CONFIG       = 8'h13;

  // Reset values and write masks
  localparam logic [7:0] DELAY_RESET      = 8'h00;
  localparam logic [7:0] OUT_CTRL_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [7:0] OUT_CTRL_WMASK   = 8'h77;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  localparam logic [3:0] CODE_NONE        = 4'h0;
  localparam logic [3:0] CODE_LAST_STEP   = 4'h1;

  typedef struct packed {
    logic [3:0] fall;   // Delay code after enable falls
    logic [3:0] rise;   // Delay code after enable rises
  } esd_delay_t;

  typedef struct packed {
    logic rsvd7;
    logic on_range;               // Startup step: 0 half ms, 1 one ms
    logic off_range;              // Shutdown step: 0 half ms, 1 one ms
    logic shared_pin_function;    // 0 general output b, 1 clock input
    logic shared_pin_pulldown;
    logic enable_pin_pulldown;
    logic thermal_warn_threshold; // 0 lower, 1 higher threshold
    logic spread_spectrum_on;
  } esd_config_t;

  typedef struct packed {
    logic rsvd7;
    logic out_b_open_drain;
    logic out_b_pin_gating;
    logic out_b_level;
    logic rsvd3;
    logic out_a_open_drain;
    logic out_a_pin_gating;
    logic out_a_level;
  } esd_out_ctrl_t;

  typedef enum logic [1:0] {
    ESD_IDLE     = 2'b00,
    ESD_WAIT_ON  = 2'b01,
    ESD_WAIT_OFF = 2'b10
  } esd_state_t;

endpackage

// ==== esd_pin_sync.sv ====
// Two-flop synchroniser for the enable pin with rise and fall pulses.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module esd_pin_sync
  import esd_pkg::*;
(
  input  wire logic i_clk,      // System clock
  input  wire logic i_reset_n,  // Async reset, active low
  input  wire logic i_pin,      // Raw pin level
  output logic      o_level,    // Synchronised level
  output logic      o_rise,     // One-cycle pulse on rise
  output logic      o_fall      // One-cycle pulse on fall
);

  logic meta;
  logic sync;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta    <= 1'b0;
      sync    <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta    <= i_pin;
      sync    <= meta;
      o_level <= sync;
    end
  end

  assign o_rise = sync & ~o_level;
  assign o_fall = ~sync & o_level;

endmodule

// ==== esd_seq_channel.sv ====
// One sequenced output: delays a level change after each enable edge.
// Assumes rise and fall pulses never arrive in the same cycle.
`timescale 1ns/1ps
module esd_seq_channel
  import esd_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_MS_CYCLES
)
(
  input  wire logic       i_clk,       // System clock
  input  wire logic       i_reset_n,   // Async reset, active low
  input  wire logic       i_rise,      // Enable rose
  input  wire logic       i_fall,      // Enable fell
  input  wire logic [3:0] i_rise_code, // Steps after rise
  input  wire logic [3:0] i_fall_code, // Steps after fall
  input  wire logic       i_on_range,  // Startup step select
  input  wire logic       i_off_range, // Shutdown step select
  output logic            o_level      // Sequenced level
);

  initial
  begin
    if (HALF_CYC < 1 || 2 * HALF_CYC > (1 << STEP_CNT_W))
      $error("esd_seq_channel: HALF_CYC out of range");
  end

  function automatic logic [STEP_CNT_W-1:0] step_last(input logic one_ms);
    step_last = one_ms ? STEP_CNT_W'(2 * HALF_CYC - 1) : STEP_CNT_W'(HALF_CYC - 1);
  endfunction

  esd_state_t            state;
  logic [3:0]            steps_left;
  logic [STEP_CNT_W-1:0] cyc_cnt;
  logic                  one_ms;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state      <= ESD_IDLE;
      steps_left <= CODE_NONE;
      cyc_cnt    <= '0;
      one_ms     <= 1'b0;
      o_level    <= 1'b0;
    end
    else if (i_rise)
    begin
      // New edge cancels any pending opposite change
      one_ms     <= i_on_range;
      steps_left <= i_rise_code;
      cyc_cnt    <= step_last(i_on_range);
      if (i_rise_code == CODE_NONE)
      begin
        o_level <= 1'b1;
        state   <= ESD_IDLE;
      end
      else
        state <= ESD_WAIT_ON;
    end
    else if (i_fall)
    begin
      one_ms     <= i_off_range;
      steps_left <= i_fall_code;
      cyc_cnt    <= step_last(i_off_range);
      if (i_fall_code == CODE_NONE)
      begin
        o_level <= 1'b0;
        state   <= ESD_IDLE;
      end
      else
        state <= ESD_WAIT_OFF;
    end
    else
    begin
      case (state)
        ESD_WAIT_ON, ESD_WAIT_OFF:
        begin
          if (cyc_cnt != '0)
            cyc_cnt <= cyc_cnt - 1'b1;
          else if (steps_left == CODE_LAST_STEP)
          begin
            o_level <= (state == ESD_WAIT_ON);
            state   <= ESD_IDLE;
          end
          else
          begin
            steps_left <= steps_left - 1'b1;
            cyc_cnt    <= step_last(one_ms);
          end
        end
        ESD_IDLE:
        begin
          state <= ESD_IDLE;
        end
        default:
        begin
          state <= ESD_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== esd_seq_top_asserts.sv ====
// Checker for the enable sequencing block; shadows register writes seen at the ports.
// Assumes HALF_CYC is handed on by the bind and the pin changes just after a clock edge.
`timescale 1ns/1ps
module esd_seq_top_asserts
  import esd_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_MS_CYCLES
)
(
  input wire logic       i_clk,                    // Clock
  input wire logic       i_reset_n,                // Reset, active low
  input wire logic       i_enable_pin,             // Enable pin
  input wire logic       i_reg_wr_en,              // Write strobe
  input wire logic [7:0] i_reg_addr,               // Address
  input wire logic [7:0] i_reg_wdata,              // Write data
  input wire logic [7:0] o_reg_rdata,              // Read data
  input wire logic       o_linear_reg_a_en,        // Regulator A
  input wire logic       o_linear_reg_b_en,        // Regulator B
  input wire logic       o_general_output_a,       // Output A
  input wire logic       o_general_output_a_oe_n,  // Output A enable
  input wire logic       o_general_output_b,       // Output B
  input wire logic       o_general_output_b_oe_n,  // Output B enable
  input wire logic       o_ext_clock_select,       // Clock input select
  input wire logic       o_shared_pin_pulldown,    // Shared pin pull-down
  input wire logic       o_enable_pin_pulldown,    // Enable pin pull-down
  input wire logic       o_thermal_warn_threshold, // Thermal threshold
  input wire logic       o_spread_spectrum_on      // Spread spectrum
);
  logic [7:0]  shadow [0:5];
  logic [7:0]  idx;
  logic [7:0]  rd_q;
  logic [15:0] since;
  logic [1:0]  age;
  logic        pin_q;

  assign idx = i_reg_addr - ADDR_LINREG_A_SEQ_DELAY;

  // Latest change seen within margin of the synchroniser and output flops
  function automatic int due(input logic [3:0] code, input logic rng);
    return 5 + int'(code) * (rng ? 2 : 1) * HALF_CYC;
  endfunction

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      for (int i = 0; i < 6; i++)
        shadow[i] <= 8'h00;
      age <= 2'h3;
    end
    else
    begin
      if (i_reg_wr_en && idx < 8'h06)
        shadow[idx[2:0]] <= (i_reg_addr == ADDR_GENERAL_OUTPUT_CTRL) ?
                            (i_reg_wdata & OUT_CTRL_WMASK) : i_reg_wdata;
      age <= i_reg_wr_en ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
    end

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
      rd_q <= 8'h00;
    else
      rd_q <= (idx < 8'h06) ? shadow[idx[2:0]] : READ_UNMAPPED;

  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      pin_q <= 1'b0;
      since <= 16'h0000;
    end
    else
    begin
      pin_q <= i_enable_pin;
      since <= (i_enable_pin != pin_q) ? 16'h0001 : ((&since) ? since : since + 16'h0001);
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_rdata_map: assert property (1'b1 |-> o_reg_rdata == rd_q)
    else $error("read data differs from written register");
  a_cfg_copy: assert property (age == 2'h3 |-> {o_ext_clock_select, o_shared_pin_pulldown,
    o_enable_pin_pulldown, o_thermal_warn_threshold, o_spread_spectrum_on} == shadow[5][4:0])
    else $error("config outputs differ from config register");
  a_outa_static: assert property (age == 2'h3 && !shadow[4][1] |->
    o_general_output_a == (shadow[4][0] & !shadow[4][2])
    && o_general_output_a_oe_n == (shadow[4][0] & shadow[4][2]))
    else $error("output A level or type wrong");
  a_outb_static: assert property (age == 2'h3 && !shadow[4][5] && !shadow[5][4] |->
    o_general_output_b == (shadow[4][4] & !shadow[4][6])
    && o_general_output_b_oe_n == (shadow[4][4] & shadow[4][6]))
    else $error("output B level or type wrong");
  a_shared_clk: assert property (age == 2'h3 && shadow[5][4] |->
    !o_general_output_b && o_general_output_b_oe_n)
    else $error("shared pin driven while clock input");
  a_lra_on: assert property (age == 2'h3 && i_enable_pin
    && int'(since) == due(shadow[0][3:0], shadow[5][6]) |-> o_linear_reg_a_en)
    else $error("regulator A late to turn on");
  a_lra_off: assert property (age == 2'h3 && !i_enable_pin
    && int'(since) == due(shadow[0][7:4], shadow[5][5]) |-> !o_linear_reg_a_en)
    else $error("regulator A late to turn off");
  a_lrb_on: assert property (age == 2'h3 && i_enable_pin
    && int'(since) == due(shadow[1][3:0], shadow[5][6]) |-> o_linear_reg_b_en)
    else $error("regulator B late to turn on");
  a_lrb_off: assert property (age == 2'h3 && !i_enable_pin
    && int'(since) == due(shadow[1][7:4], shadow[5][5]) |-> !o_linear_reg_b_en)
    else $error("regulator B late to turn off");
  a_outa_gated: assert property (age == 2'h3 && i_enable_pin && shadow[4][2:0] == 3'h3
    && int'(since) == due(shadow[2][3:0], shadow[5][6]) + 1 |-> o_general_output_a)
    else $error("gated output A late to rise");
endmodule

bind esd_seq_top esd_seq_top_asserts #(.HALF_CYC(HALF_CYC)) u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_enable_pin(i_enable_pin),
  .i_reg_wr_en(i_reg_wr_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_linear_reg_a_en(o_linear_reg_a_en),
  .o_linear_reg_b_en(o_linear_reg_b_en), .o_general_output_a(o_general_output_a),
  .o_general_output_a_oe_n(o_general_output_a_oe_n), .o_general_output_b(o_general_output_b),
  .o_general_output_b_oe_n(o_general_output_b_oe_n), .o_ext_clock_select(o_ext_clock_select),
  .o_shared_pin_pulldown(o_shared_pin_pulldown), .o_enable_pin_pulldown(o_enable_pin_pulldown),
  .o_thermal_warn_threshold(o_thermal_warn_threshold),
  .o_spread_spectrum_on(o_spread_spectrum_on));

// ==== esd_seq_top_tb.sv ====
// Self-checking bench for the enable sequencing block with an integer register model.
// Assumes a step of 4 cycles per half ms; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module esd_seq_top_tb
  import esd_pkg::*;
;
  localparam int HC = 4;
  logic       i_clk        = 1'b0;
  logic       i_reset_n    = 1'b0;
  logic       i_enable_pin = 1'b0;
  logic       i_reg_wr_en  = 1'b0;
  logic [7:0] i_reg_addr   = 8'h00;
  logic [7:0] i_reg_wdata  = 8'h00;
  logic [7:0] o_reg_rdata;
  logic       lra, lrb, ga, ga_oe_n, gb, gb_oe_n, ext, spd, epd, thr, ssp;
  logic [7:0] obs;
  logic [7:0] cfg_obs;
  logic [7:0] code_tab [0:3] = '{8'h0F, 8'hF0, 8'h00, 8'hFF};
  logic [7:0] ctrl_tab [0:3] = '{8'h33, 8'h77, 8'h11, 8'h22};
  int         failures = 0;
  int         samples_checked = 0;
  int         mdl [0:5];
  int         st [0:3];

  assign obs = {2'b00, lra, lrb, ga, ga_oe_n, gb, gb_oe_n};
  assign cfg_obs = {3'b000, ext, spd, epd, thr, ssp};

  esd_seq_top #(.HALF_CYC(HC)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_enable_pin(i_enable_pin),
    .i_reg_wr_en(i_reg_wr_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_linear_reg_a_en(lra), .o_linear_reg_b_en(lrb),
    .o_general_output_a(ga), .o_general_output_a_oe_n(ga_oe_n), .o_general_output_b(gb),
    .o_general_output_b_oe_n(gb_oe_n), .o_ext_clock_select(ext), .o_shared_pin_pulldown(spd),
    .o_enable_pin_pulldown(epd), .o_thermal_warn_threshold(thr), .o_spread_spectrum_on(ssp));

  always #50 i_clk = ~i_clk;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr_en = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick();
    i_reg_wr_en = 1'b0;
    tick();
    if (a >= ADDR_LINREG_A_SEQ_DELAY && a <= ADDR_DEVICE_CONFIG)
      mdl[a - ADDR_LINREG_A_SEQ_DELAY] = (a == ADDR_GENERAL_OUTPUT_CTRL) ? d & OUT_CTRL_WMASK : d;
  endtask

  task automatic rd(input logic [7:0] a);
    i_reg_addr = a;
    tick();
    if (a >= ADDR_LINREG_A_SEQ_DELAY && a <= ADDR_DEVICE_CONFIG)
      chk(o_reg_rdata, 8'(mdl[a - ADDR_LINREG_A_SEQ_DELAY]));
    else
      chk(o_reg_rdata, READ_UNMAPPED);
  endtask

  // Pin values from the model's registers and channel levels
  function automatic logic [7:0] exp_out();
    logic [7:0] c;
    logic       f;
    logic       va;
    logic       vb;
    c = 8'(mdl[4]);
    f = mdl[5][4];
    va = c[0] & (~c[1] | st[2][0]);
    vb = c[4] & (~c[5] | st[3][0]);
    return {2'b00, st[0][0], st[1][0], va & ~c[2], va & c[2], vb & ~c[6] & ~f, f | (vb & c[6])};
  endfunction

  // Edge on the pin, then compare for span cycles; two-cycle slack at each change
  task automatic edge_run(input logic v, input int span);
    int   lat [0:3];
    int   old [0:3];
    logic sk;
    for (int i = 0; i < 4; i++)
    begin
      lat[i] = 4 + (v ? mdl[i] % 16 : mdl[i] / 16) * (mdl[5][v ? 6 : 5] ? 2 : 1) * HC;
      old[i] = st[i];
    end
    i_enable_pin = v;
    for (int k = 1; k <= span; k++)
    begin
      tick();
      sk = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        st[i] = (k >= lat[i]) ? int'(v) : old[i];
        sk = sk | (k == lat[i]) | (k == lat[i] + 1);
      end
      if (!sk)
        chk(obs, exp_out());
    end
  endtask

  initial
  begin
    #(100 * 20000);
    failures++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(13));
    for (int i = 0; i < 6; i++)
      mdl[i] = 0;
    for (int i = 0; i < 4; i++)
      st[i] = 0;
    tick(2);
    i_reset_n = 1'b1;
    tick();
    chk(obs, 8'h00);
    for (int a = 8'h0D; a <= 8'h14; a++)
      rd(8'(a));
    for (int a = 8'h0E; a <= 8'h13; a++)
    begin
      wr(8'(a), 8'($urandom));
      rd(8'(a));
    end
    wr(8'h20, 8'hFF);
    rd(8'h20);
    rd(ADDR_LINREG_A_SEQ_DELAY);
    for (int n = 0; n < 8; n++)
    begin
      wr(ADDR_GENERAL_OUTPUT_CTRL, 8'($urandom));
      wr(ADDR_DEVICE_CONFIG, 8'($urandom));
      tick();
      chk(cfg_obs, {3'b000, 5'(mdl[5])});
      chk(obs, exp_out());
    end
    for (int it = 0; it < 4; it++)
    begin
      for (int a = 0; a < 4; a++)
        wr(ADDR_LINREG_A_SEQ_DELAY + 8'(a), it == 0 ? code_tab[a] : 8'($urandom));
      wr(ADDR_GENERAL_OUTPUT_CTRL, ctrl_tab[it]);
      wr(ADDR_DEVICE_CONFIG, {1'b0, it[0], it[1], it == 3, 4'h0});
      edge_run(1'b1, 140);
      edge_run(1'b0, 140);
    end
    for (int a = 0; a < 4; a++)
      wr(ADDR_LINREG_A_SEQ_DELAY + 8'(a), 8'h0F);
    wr(ADDR_GENERAL_OUTPUT_CTRL, 8'h33);
    wr(ADDR_DEVICE_CONFIG, 8'h40);
    edge_run(1'b1, 20);
    edge_run(1'b0, 20);
    edge_run(1'b1, 130);
    end_of_test();
  end
endmodule
